// ==== mii_sense_pkg.sv ====
// Package of constants and types for the MII collision and carrier sense block
package mii_sense_pkg;

    // Clock and timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int HB_DELAY_NS = 800;
    localparam int HB_WIDTH_NS = 1000;
    localparam int HB_DELAY_CYC = (HB_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HB_WIDTH_CYC = (HB_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HB_CNT_W = 8;

    // Code group length for 100 Mb/s activity detection
    localparam int CODE_GROUP_W = 10;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h08;
    localparam logic [7:0] OFF_IRQ_CLEAR = 8'h0C;
    localparam logic [7:0] OFF_IRQ_ENABLE = 8'h10;

    // Control register field positions
    localparam int CTRL_FULL_DUPLEX = 0;
    localparam int CTRL_SPEED_100 = 1;
    localparam int CTRL_HB_SUPPRESS = 2;
    localparam int CTRL_REPEATER = 3;
    localparam int CTRL_MDIO_DRIVE = 4;
    localparam int CTRL_MDIO_BIT = 5;
    localparam int CTRL_W = 6;

    // Status register field positions
    localparam int STAT_COL = 0;
    localparam int STAT_CRS = 1;
    localparam int STAT_RX_ACT = 2;
    localparam int STAT_TX_ACT = 3;
    localparam int STAT_MDIO_LSB = 16;
    localparam int MDIO_SHIFT_W = 16;

    // Interrupt event bit positions
    localparam int EV_COLLISION = 0;
    localparam int EV_CARRIER = 1;
    localparam int EV_HEARTBEAT = 2;
    localparam int EV_W = 3;

    // Reset values
    localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;
    localparam logic [EV_W-1:0] IRQ_ENABLE_RESET = 3'h0;

    // Operating mode carried as one bundle
    typedef struct packed {
        logic mdio_bit;
        logic mdio_drive;
        logic repeater;
        logic hb_suppress;
        logic speed_100;
        logic full_duplex;
    } mode_t;

    // Heartbeat test sequencer
    typedef enum logic [1:0] {
        HB_IDLE = 2'b00,
        HB_WAIT = 2'b01,
        HB_PULSE = 2'b10
    } hb_state_t;

endpackage : mii_sense_pkg

// ==== code_group_activity.sv ====
// 100 Mb/s receive activity detector over a sliding code group window
`timescale 1ns/1ps
module code_group_activity
    import mii_sense_pkg::*;
(
    input wire logic clock_in,
    input wire logic arst_n_in,
    input wire logic bit_in,
    input wire logic bit_valid_in,
    output logic active_out
);

    logic [CODE_GROUP_W-1:0] window_q;
    logic [CODE_GROUP_W-1:0] window_d;
    logic active_q;
    logic active_d;

    // True when two zeros with at least one bit between them exist
    function automatic logic split_zeros(input logic [CODE_GROUP_W-1:0] w);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < CODE_GROUP_W - 2; i++) begin
            for (int j = i + 2; j < CODE_GROUP_W; j++) begin
                hit = hit | (~w[i] & ~w[j]);
            end
        end
        return hit;
    endfunction

    // Shift the newest line bit in; idle line is all ones
    assign window_d = bit_valid_in ? {window_q[CODE_GROUP_W-2:0], bit_in}
                                   : window_q;
    assign active_d = split_zeros(window_d);

    // Window and activity flag registers
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            window_q <= '1;
            active_q <= 1'b0;
        end else begin
            window_q <= window_d;
            active_q <= active_d;
        end
    end

    assign active_out = active_q;

endmodule // code_group_activity

// ==== mii_collision_carrier_sense.sv ====
// MII collision, carrier sense and management pin logic with Wishbone slave
// Overview of operation
// - Collision rises when receive activity is seen while transmit enable is held.
// - At 10 Mb/s receive activity is taken from the line signal before squelch.
// - At 100 Mb/s receive activity is any 10-bit group with two non-adjacent zeros.
// - Collision is tied to neither receive nor transmit clock; the MAC syncs it.
// - In full duplex collision signalling is off and the output stays low.
// - Collision pulses as a heartbeat test unless heartbeat_check_suppress is set.
// - In half duplex outside repeater mode carrier sense follows receive or transmit activity.
// - In full duplex or repeater mode carrier sense follows receive activity only.
// - Carrier sense is tied to neither receive nor transmit clock.
// - The management data line is released by each side when not driving it.
// - The management data line is driven and sampled only on management clock edges.
`timescale 1ns/1ps
module mii_collision_carrier_sense
    import mii_sense_pkg::*;
(
    input wire logic clock_in,
    input wire logic arst_n_in,
    // Wishbone classic slave
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    // Line side activity
    input wire logic tx_enable_in,
    input wire logic rx_unsquelched_in,
    input wire logic rx_code_bit_in,
    input wire logic rx_code_valid_in,
    // MII status toward the MAC
    output logic col_out,
    output logic crs_out,
    // Management pins
    input wire logic mdc_in,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe_out,
    // Interrupt
    output logic irq_out
);

    localparam int SYNC_N = 4;

    // Synchroniser stages for pin inputs
    logic [SYNC_N-1:0] pin_raw;
    logic [SYNC_N-1:0] sync1_q;
    logic [SYNC_N-1:0] sync2_q;
    logic tx_en_s;
    logic rx_unsq_s;
    logic mdc_s;
    logic mdio_s;

    // Register state
    logic [CTRL_W-1:0] ctrl_q;
    logic [CTRL_W-1:0] ctrl_d;
    logic [EV_W-1:0] irq_sts_q;
    logic [EV_W-1:0] irq_sts_d;
    logic [EV_W-1:0] irq_en_q;
    logic [EV_W-1:0] irq_en_d;
    logic [31:0] rd_data_d;
    logic [31:0] rd_q;
    logic ack_q;
    logic irq_q;
    mode_t mode;

    // Line activity and output state
    logic rx_act_100;
    logic rx_act;
    logic tx_act;
    logic col_d;
    logic col_q;
    logic crs_d;
    logic crs_q;
    logic col_seen_q;
    logic crs_seen_q;
    logic tx_prev_q;
    logic tx_fall;
    logic [EV_W-1:0] events;

    // Heartbeat sequencer
    hb_state_t hb_state_q;
    hb_state_t hb_state_d;
    logic [HB_CNT_W-1:0] hb_cnt_q;
    logic [HB_CNT_W-1:0] hb_cnt_d;
    logic hb_pulse;
    logic hb_done;

    // Management pin state
    logic mdc_prev_q;
    logic mdc_rise;
    logic [MDIO_SHIFT_W-1:0] mdio_shift_q;
    logic mdio_q;
    logic mdio_oe_q;

    // Bus decode
    logic bus_req;
    logic wr_strobe;
    logic [31:0] wmask;
    logic hit_ctrl;
    logic hit_status;
    logic hit_irq_sts;
    logic hit_irq_clr;
    logic hit_irq_en;
    logic [EV_W-1:0] clr_bits;

    // Address match on a word offset
    function automatic logic reg_hit(input logic [7:0] adr,
                                     input logic [7:0] off);
        return adr[7:2] == off[7:2];
    endfunction

    // Expand byte selects into a bit mask
    function automatic logic [31:0] lane_mask(input logic [3:0] sel);
        logic [31:0] m;
        m = '0;
        for (int b = 0; b < 4; b++) begin
            m[b*8 +: 8] = {8{sel[b]}};
        end
        return m;
    endfunction

    // Pins from other clock domains pass two flip-flops
    assign pin_raw = {mdio_in, mdc_in, rx_unsquelched_in, tx_enable_in};

    // Two flip-flops per pin; only the second stage feeds logic
    genvar g;
    generate
        for (g = 0; g < SYNC_N; g++) begin : g_sync
            always_ff @(posedge clock_in or negedge arst_n_in) begin
                if (!arst_n_in) begin
                    sync1_q[g] <= 1'b0;
                    sync2_q[g] <= 1'b0;
                end else begin
                    sync1_q[g] <= pin_raw[g];
                    sync2_q[g] <= sync1_q[g];
                end
            end
        end
    endgenerate

    // Synchronised pin levels
    assign tx_en_s = sync2_q[0];
    assign rx_unsq_s = sync2_q[1];
    assign mdc_s = sync2_q[2];
    assign mdio_s = sync2_q[3];

    // Control bits viewed as the mode bundle
    assign mode = mode_t'(ctrl_q);

    // 100 Mb/s code group activity detector
    code_group_activity u_cg_act (
        .clock_in(clock_in),
        .arst_n_in(arst_n_in),
        .bit_in(rx_code_bit_in),
        .bit_valid_in(rx_code_valid_in),
        .active_out(rx_act_100)
    );

    // Receive activity by speed; transmit activity is the MAC's enable
    assign rx_act = mode.speed_100 ? rx_act_100
                                   : rx_unsq_s;
    assign tx_act = tx_en_s;
    assign tx_fall = tx_prev_q & ~tx_en_s;

    // Heartbeat: wait after end of transmit, then pulse collision
    assign hb_done = hb_cnt_q == '0;
    assign hb_pulse = hb_state_q == HB_PULSE;

    // Heartbeat next state; any abort condition returns to idle
    always_comb begin
        hb_state_d = hb_state_q;
        hb_cnt_d = hb_cnt_q;
        case (hb_state_q)
            HB_IDLE: begin
                if (tx_fall && !mode.full_duplex && !mode.hb_suppress) begin
                    hb_state_d = HB_WAIT;
                    hb_cnt_d = HB_CNT_W'(HB_DELAY_CYC - 1);
                end
            end
            HB_WAIT: begin
                if (mode.hb_suppress || mode.full_duplex || tx_act) begin
                    hb_state_d = HB_IDLE;
                end else if (hb_done) begin
                    hb_state_d = HB_PULSE;
                    hb_cnt_d = HB_CNT_W'(HB_WIDTH_CYC - 1);
                end else begin
                    hb_cnt_d = hb_cnt_q - 1'b1;
                end
            end
            HB_PULSE: begin
                if (mode.hb_suppress || mode.full_duplex || hb_done) begin
                    hb_state_d = HB_IDLE;
                end else begin
                    hb_cnt_d = hb_cnt_q - 1'b1;
                end
            end
            default: begin
                hb_state_d = HB_IDLE;
                hb_cnt_d = '0;
            end
        endcase
    end

    // Collision and carrier sense, combined from current conditions
    assign col_d = ~mode.full_duplex
                 & ((tx_act & rx_act) | hb_pulse);
    assign crs_d = (mode.full_duplex | mode.repeater) ? rx_act
                                                      : rx_act | tx_act;

    // Status output registers, free of the MII clocks
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            col_q <= 1'b0;
            crs_q <= 1'b0;
            tx_prev_q <= 1'b0;
            col_seen_q <= 1'b0;
            crs_seen_q <= 1'b0;
        end else begin
            col_q <= col_d;
            crs_q <= crs_d;
            tx_prev_q <= tx_en_s;
            col_seen_q <= col_q;
            crs_seen_q <= crs_q;
        end
    end

    // Heartbeat sequencer registers
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            hb_state_q <= HB_IDLE;
            hb_cnt_q <= '0;
        end else begin
            hb_state_q <= hb_state_d;
            hb_cnt_q <= hb_cnt_d;
        end
    end

    // Management clock edge from the synchronised pin
    assign mdc_rise = mdc_s & ~mdc_prev_q;

    // Management data: sample and drive only at management clock edges
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            mdc_prev_q <= 1'b0;
            mdio_shift_q <= '0;
            mdio_q <= 1'b0;
            mdio_oe_q <= 1'b0;
        end else begin
            mdc_prev_q <= mdc_s;
            if (mdc_rise) begin
                mdio_shift_q <= {mdio_shift_q[MDIO_SHIFT_W-2:0], mdio_s};
                mdio_q <= mode.mdio_bit & mode.mdio_drive;
                mdio_oe_q <= mode.mdio_drive;
            end
        end
    end

    // Bus decode
    assign bus_req = wb_cyc_in & wb_stb_in & ~ack_q;
    assign wr_strobe = bus_req & wb_we_in;
    assign wmask = lane_mask(wb_sel_in);
    assign hit_ctrl = reg_hit(wb_adr_in, OFF_CTRL);
    assign hit_status = reg_hit(wb_adr_in, OFF_STATUS);
    assign hit_irq_sts = reg_hit(wb_adr_in, OFF_IRQ_STATUS);
    assign hit_irq_clr = reg_hit(wb_adr_in, OFF_IRQ_CLEAR);
    assign hit_irq_en = reg_hit(wb_adr_in, OFF_IRQ_ENABLE);

    // Register writes honour byte lanes
    assign ctrl_d = (wr_strobe && hit_ctrl)
                  ? ((ctrl_q & ~wmask[CTRL_W-1:0])
                     | (wb_dat_in[CTRL_W-1:0] & wmask[CTRL_W-1:0]))
                  : ctrl_q;
    assign irq_en_d = (wr_strobe && hit_irq_en)
                    ? ((irq_en_q & ~wmask[EV_W-1:0])
                       | (wb_dat_in[EV_W-1:0] & wmask[EV_W-1:0]))
                    : irq_en_q;
    assign clr_bits = (wr_strobe && hit_irq_clr)
                    ? (wb_dat_in[EV_W-1:0] & wmask[EV_W-1:0])
                    : '0;

    // Events: rising collision, rising carrier, heartbeat start
    assign events[EV_COLLISION] = col_q & ~col_seen_q;
    assign events[EV_CARRIER] = crs_q & ~crs_seen_q;
    assign events[EV_HEARTBEAT] = hb_pulse & (hb_state_d == HB_PULSE)
                                & (hb_cnt_q == HB_CNT_W'(HB_WIDTH_CYC - 1));

    // Sticky status: a new event wins over a clear in the same cycle
    assign irq_sts_d = (irq_sts_q & ~clr_bits) | events;

    // Read data selection; unmapped and write-only offsets read zero
    always_comb begin
        rd_data_d = '0;
        if (hit_ctrl) begin
            rd_data_d[CTRL_W-1:0] = ctrl_q;
        end else if (hit_status) begin
            rd_data_d[STAT_COL] = col_q;
            rd_data_d[STAT_CRS] = crs_q;
            rd_data_d[STAT_RX_ACT] = rx_act;
            rd_data_d[STAT_TX_ACT] = tx_act;
            rd_data_d[STAT_MDIO_LSB +: MDIO_SHIFT_W] = mdio_shift_q;
        end else if (hit_irq_sts) begin
            rd_data_d[EV_W-1:0] = irq_sts_q;
        end else if (hit_irq_en) begin
            rd_data_d[EV_W-1:0] = irq_en_q;
        end
    end

    // Register file and single-cycle acknowledge
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ctrl_q <= CTRL_RESET;
            irq_en_q <= IRQ_ENABLE_RESET;
            irq_sts_q <= '0;
            ack_q <= 1'b0;
            rd_q <= '0;
            irq_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            irq_en_q <= irq_en_d;
            irq_sts_q <= irq_sts_d;
            ack_q <= bus_req;
            rd_q <= bus_req ? rd_data_d : '0;
            irq_q <= |(irq_sts_d & irq_en_d);
        end
    end

    // Outputs straight from flip-flops
    assign col_out = col_q;
    assign crs_out = crs_q;
    assign mdio_out = mdio_q;
    assign mdio_oe_out = mdio_oe_q;
    assign wb_ack_out = ack_q;
    assign wb_dat_out = rd_q;
    assign irq_out = irq_q;

endmodule // mii_collision_carrier_sense

// ==== mii_collision_carrier_sense_checker.sv ====
// Checker of collision, carrier sense and management pin timing
`timescale 1ns/1ps
module mii_sense_checker (
    input wire logic clock_in,
    input wire logic arst_n_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    input wire logic wb_ack_out,
    input wire logic tx_enable_in,
    input wire logic rx_unsquelched_in,
    input wire logic mdc_in,
    input wire logic mdio_out,
    input wire logic mdio_oe_out,
    input wire logic col_out,
    input wire logic crs_out
);
    logic [3:0] mode_q;
    logic take;
    wire fd = mode_q[0];
    wire s100 = mode_q[1];
    wire sup = mode_q[2];
    wire rep = mode_q[3];

    // Control writes seen on the bus
    assign take = wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out
        && wb_adr_in[7:2] == 6'h00 && wb_sel_in[0];

    // Shadow copy of the mode bits
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            mode_q <= 4'h0;
        end else if (take) begin
            mode_q <= wb_dat_in[3:0];
        end
    end

    default clocking @(posedge clock_in); endclocking
    default disable iff (!arst_n_in);

    // Line quiet after transmit ends
    sequence quiet8;
        (!tx_enable_in && !rx_unsquelched_in)[*8];
    endsequence

    chk_col_on: assert property (
        (!fd && !s100 && tx_enable_in && rx_unsquelched_in)[*4] |=> col_out)
        else $error("collision missing");
    chk_col_fd: assert property (
        fd[*3] |-> !col_out)
        else $error("collision in full duplex");
    chk_crs_half: assert property (
        (!fd && !rep && tx_enable_in)[*4] |=> crs_out)
        else $error("carrier missing on transmit");
    chk_crs_rx: assert property (
        ((fd || rep) && !s100 && !rx_unsquelched_in)[*4] |=> !crs_out)
        else $error("carrier from own transmit");
    chk_crs_drop: assert property (
        (!s100 && !tx_enable_in && !rx_unsquelched_in)[*4] |=> !crs_out)
        else $error("carrier stuck");
    chk_hb_pulse: assert property (
        $fell(tx_enable_in) && !fd && !sup ##1 quiet8 |-> ##[70:90] col_out)
        else $error("heartbeat missing");
    chk_hb_block: assert property (
        $fell(tx_enable_in) && sup ##1 quiet8 |-> ##80 (!col_out)[*8])
        else $error("heartbeat not suppressed");
    chk_mdio_step: assert property (
        ($changed(mdio_out) || $changed(mdio_oe_out))
        |-> $past(mdc_in, 2) || $past(mdc_in, 3) || $past(mdc_in, 4))
        else $error("management pin moved off clock");
endmodule // mii_sense_checker

bind mii_collision_carrier_sense mii_sense_checker checker_i (.*);

// ==== mac_sta_model.sv ====
// Model of the MAC and station manager facing the block
`timescale 1ns/1ps
module mac_sta_model (
    input wire logic clock_in,
    input wire logic mdio_out_in,
    input wire logic mdio_oe_in,
    output logic tx_enable_out,
    output logic rx_active_out,
    output logic mdc_out,
    output logic mdio_line_out
);
    // Manager only listens; the pull-down holds a released line low
    assign mdio_line_out = mdio_oe_in ? mdio_out_in : 1'h0;

    // Idle lines and a still management clock
    initial begin
        tx_enable_out = 1'h0;
        rx_active_out = 1'h0;
        mdc_out = 1'h0;
    end

    // Transmit and line activity change just after an edge
    task automatic set_lines(input logic tx, input logic rx);
        @(posedge clock_in);
        tx_enable_out <= tx;
        rx_active_out <= rx;
    endtask

    // One management clock period, still outside it
    task automatic mdc_cycle();
        @(posedge clock_in);
        mdc_out <= 1'h1;
        repeat (5) @(posedge clock_in);
        mdc_out <= 1'h0;
        repeat (5) @(posedge clock_in);
    endtask
endmodule // mac_sta_model

// ==== mii_collision_carrier_sense_test.sv ====
// Testbench of the collision and carrier sense block
`timescale 1ns/1ps
module mii_collision_carrier_sense_test;
    import mii_sense_pkg::*;
    logic clock_in, arst_n_in, cyc, stb, we, ack, cbit, cval;
    logic tx, rx, mdc, line, mout, moe, col_out, crs_out, irq_out;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat, rdat, rd;
    int mismatches = 0;
    int comparisons = 0;

    mii_collision_carrier_sense uut (.clock_in(clock_in),
        .arst_n_in(arst_n_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dat),
        .wb_dat_out(rdat), .wb_ack_out(ack), .tx_enable_in(tx),
        .rx_unsquelched_in(rx), .rx_code_bit_in(cbit),
        .rx_code_valid_in(cval), .col_out(col_out), .crs_out(crs_out),
        .mdc_in(mdc), .mdio_in(line), .mdio_out(mout), .mdio_oe_out(moe),
        .irq_out(irq_out));
    mac_sta_model mac (.clock_in(clock_in), .mdio_out_in(mout),
        .mdio_oe_in(moe), .tx_enable_out(tx), .rx_active_out(rx),
        .mdc_out(mdc), .mdio_line_out(line));

    // Clock
    always #5 clock_in = ~clock_in;

    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] pins();
        return {29'h0, irq_out, col_out, crs_out};
    endfunction

    task automatic ticks(input int n);
        repeat (n) @(posedge clock_in);
    endtask

    // One classic bus cycle, held until acknowledged
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        @(posedge clock_in);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        dat <= d;
        // The wait ends on the acknowledge; only the watchdog ends one that never comes
        do begin
            @(posedge clock_in);
        end while (ack !== 1'h1);
        rd = rdat;
        cyc <= 1'h0;
        stb <= 1'h0;
        we <= 1'h0;
    endtask

    // Ten line bits at 100 Mb/s, first bit in b[0]
    task automatic bits(input logic [9:0] b);
        for (int i = 0; i < 10; i++) begin
            @(posedge clock_in);
            cbit <= b[i];
            cval <= 1'h1;
        end
        @(posedge clock_in);
        cval <= 1'h0;
    endtask

    task automatic t_regs();
        wb(0, OFF_CTRL, 32'h0);
        check(rd, 32'h0);
        wb(0, 8'h1C, 32'h0);
        check(rd, 32'h0);
        wb(1, OFF_STATUS, 32'hFFFFFFFF);
        wb(0, OFF_STATUS, 32'h0);
        check(rd, 32'h0);
        wb(1, OFF_IRQ_ENABLE, 32'h1);
        wb(0, OFF_IRQ_ENABLE, 32'h0);
        check(rd, 32'h1);
    endtask

    task automatic t_collision();
        mac.set_lines(1, 1);
        ticks(6);
        check(pins(), 32'h7);
        wb(0, OFF_STATUS, 32'h0);
        check(rd, 32'hF);
        wb(0, OFF_IRQ_STATUS, 32'h0);
        check(rd, 32'h3);
        wb(1, OFF_IRQ_CLEAR, 32'h1);
        ticks(2);
        check(pins(), 32'h3);
        wb(1, OFF_IRQ_ENABLE, 32'h2);
        ticks(2);
        check(pins(), 32'h7);
        wb(1, OFF_IRQ_ENABLE, 32'h0);
        mac.set_lines(0, 0);
        ticks(6);
        check(pins(), 32'h0);
        ticks(89);
        check(pins(), 32'h2);
        ticks(110);
        check(pins(), 32'h0);
        wb(0, OFF_IRQ_STATUS, 32'h0);
        check(rd & 32'h4, 32'h4);
    endtask

    task automatic t_suppress();
        wb(1, OFF_CTRL, 32'h4);
        mac.set_lines(1, 0);
        ticks(5);
        check(pins(), 32'h1);
        mac.set_lines(0, 0);
        ticks(90);
        check(pins(), 32'h0);
        ticks(20);
    endtask

    task automatic t_modes();
        wb(1, OFF_CTRL, 32'h1);
        mac.set_lines(1, 1);
        ticks(6);
        check(pins(), 32'h1);
        mac.set_lines(1, 0);
        ticks(6);
        check(pins(), 32'h0);
        wb(1, OFF_CTRL, 32'hC);
        ticks(6);
        check(pins(), 32'h0);
        mac.set_lines(1, 1);
        ticks(6);
        check(pins(), 32'h3);
        mac.set_lines(0, 0);
        ticks(6);
    endtask

    task automatic t_fast();
        wb(1, OFF_CTRL, 32'h6);
        mac.set_lines(1, 0);
        bits(10'h3FF);
        bits(10'h3F9);
        ticks(3);
        check(pins(), 32'h1);
        bits(10'h3F5);
        ticks(3);
        check(pins(), 32'h3);
        bits(10'h3FF);
        ticks(3);
        check(pins(), 32'h1);
        mac.set_lines(0, 0);
        ticks(100);
    endtask

    task automatic t_mdio();
        wb(1, OFF_CTRL, 32'h30);
        mac.mdc_cycle();
        check({30'h0, moe, mout}, 32'h3);
        mac.mdc_cycle();
        wb(1, OFF_CTRL, 32'h0);
        mac.mdc_cycle();
        check({30'h0, moe, mout}, 32'h0);
        mac.mdc_cycle();
        wb(0, OFF_STATUS, 32'h0);
        check(rd & 32'h000F000F, 32'h00060000);
    endtask

    // Reset, then the scenarios in turn
    initial begin
        clock_in = 1'h0;
        arst_n_in = 1'h0;
        {cyc, stb, we, cbit, cval} = 5'h0;
        adr = 8'h0;
        sel = 4'hF;
        dat = 32'h0;
        ticks(12);
        arst_n_in <= 1'h1;
        t_regs();
        t_collision();
        t_suppress();
        t_modes();
        t_fast();
        t_mdio();
        results();
    end

    // Watchdog against a hung handshake
    initial begin
        #100000;
        mismatches++;
        results();
    end
endmodule // mii_collision_carrier_sense_test
